/* hw/sesr_pkg.sv */
package sesr_pkg;

    // ------------------------------------------------------------------
    // address windows
    // ------------------------------------------------------------------
    localparam logic [31:0] SESR_PRIV_BASE   = 32'hfed2_0000; // special and private windows
    localparam logic [31:0] SESR_PUB_BASE    = 32'hfed3_0000; // public window
    localparam logic [31:0] SESR_WIN_MASK    = 32'hffff_0000; // 64 KiB per window
    localparam logic [15:0] SESR_STATUS_OFS  = 16'h0000;      // engine_status offset

    // ------------------------------------------------------------------
    // engine_status field positions
    // ------------------------------------------------------------------
    localparam int SESR_SEQ_BIT = 17;
    localparam int SESR_L2_BIT  = 16;
    localparam int SESR_L1_BIT  = 15;
    localparam int SESR_L3_BIT  = 14;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic       SESR_FLAG_RST   = 1'b0;
    localparam logic [1:0] SESR_DECODE_LAT = 2'h1; // cycles the visible flags trail the decode state

    // decoded window of an access
    typedef enum logic [1:0] {
        SESR_WIN_NONE,
        SESR_WIN_SPECIAL,
        SESR_WIN_PRIVATE,
        SESR_WIN_PUBLIC
    } sesr_win_t;

endpackage : sesr_pkg

/* hw/sesr_status_regs.sv */
`timescale 1ns/10ps

module sesr_status_regs (
    input  wire logic        mclk_in,                // 25 MHz platform clock
    input  wire logic        rstn_in,                // system reset, active low
    input  wire logic        acc_valid_in,           // register access request
    input  wire logic        acc_write_in,           // 1 write, 0 read
    input  wire logic        acc_special_in,         // dedicated secure command type
    input  wire logic [31:0] acc_addr_in,            // byte address
    input  wire logic [31:0] acc_wdata_in,           // write data (unused by status)
    input  wire logic        sequence_begin_msg_in,  // processor sequence-begin pulse
    input  wire logic        sequence_end_msg_in,    // processor sequence-end pulse
    input  wire logic        open_level1_cmd_in,     // open level one
    input  wire logic        close_level1_cmd_in,    // close level one
    input  wire logic        open_level2_cmd_in,     // open level two
    input  wire logic        close_level2_cmd_in,    // close level two
    input  wire logic        open_level3_cmd_in,     // open level three
    input  wire logic        close_level3_cmd_in,    // close level three
    input  wire logic        open_private_cmd_in,    // open private
    input  wire logic        close_private_cmd_in,   // close private
    input  wire logic        improper_exit_in,       // thread left environment badly
    input  wire logic        rogue_clear_in,         // write-one-to-clear of rogue flag
    output logic             acc_ready_out,          // access accepted this cycle
    output logic [31:0]      acc_rdata_out,          // read data
    output logic [1:0]       acc_window_out,         // decoded window of access
    output logic             acc_write_done_out,     // write took effect somewhere
    output logic             level1_dec_out,         // level1 state used by decode
    output logic             level2_dec_out,         // level2 state used by decode
    output logic             level3_dec_out,         // level3 state used by decode
    output logic             rogue_error_flag_out,   // rogue flag of error status
    output logic             secure_platform_reset_n_out // secure reset, active low
);

    // ------------------------------------------------------------------
    // window decode
    // ------------------------------------------------------------------
    function automatic sesr_pkg::sesr_win_t win_of(input logic [31:0] a, input logic sp);
        sesr_pkg::sesr_win_t w;
        w = sesr_pkg::SESR_WIN_NONE;
        if ((a & sesr_pkg::SESR_WIN_MASK) == sesr_pkg::SESR_PRIV_BASE) begin
            w = sp ? sesr_pkg::SESR_WIN_SPECIAL : sesr_pkg::SESR_WIN_PRIVATE;
        end else if ((a & sesr_pkg::SESR_WIN_MASK) == sesr_pkg::SESR_PUB_BASE) begin
            w = sesr_pkg::SESR_WIN_PUBLIC;
        end
        return w;
    endfunction : win_of

    sesr_pkg::sesr_win_t win_now;
    logic                is_status;
    logic [15:0]         acc_ofs;

    // offset in window is the same for every base, so one storage serves all
    assign win_now   = win_of(acc_addr_in, acc_special_in);
    assign acc_ofs   = acc_addr_in[15:0];
    assign is_status = (win_now != sesr_pkg::SESR_WIN_NONE)
                     && (acc_ofs == sesr_pkg::SESR_STATUS_OFS);
    assign acc_ready_out = acc_valid_in;

    // ------------------------------------------------------------------
    // decode-side level state (takes effect first)
    // ------------------------------------------------------------------
    logic l1_dec_q, l2_dec_q, l3_dec_q;

    // decode state changes at once; the visible flags trail it
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            l1_dec_q <= sesr_pkg::SESR_FLAG_RST;
            l2_dec_q <= sesr_pkg::SESR_FLAG_RST;
            l3_dec_q <= sesr_pkg::SESR_FLAG_RST;
        end else begin
            if (open_level1_cmd_in) begin
                l1_dec_q <= 1'b1;
            end else if (close_level1_cmd_in) begin
                l1_dec_q <= 1'b0;
            end
            if (open_level2_cmd_in || open_private_cmd_in) begin
                l2_dec_q <= 1'b1;
            end else if (close_level2_cmd_in || close_private_cmd_in) begin
                l2_dec_q <= 1'b0;
            end
            if (open_level3_cmd_in) begin
                l3_dec_q <= 1'b1;
            end else if (close_level3_cmd_in) begin
                l3_dec_q <= 1'b0;
            end
        end
    end

    assign level1_dec_out = l1_dec_q;
    assign level2_dec_out = l2_dec_q;
    assign level3_dec_out = l3_dec_q;

    // ------------------------------------------------------------------
    // visible open flags
    // ------------------------------------------------------------------
    logic level1_open_flag_q, level2_open_flag_q, level3_open_flag_q;

    // copy from decode state one cycle later, so a read that sees the new
    // value is guaranteed to be decoded under it
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            level1_open_flag_q <= sesr_pkg::SESR_FLAG_RST;
            level2_open_flag_q <= sesr_pkg::SESR_FLAG_RST;
            level3_open_flag_q <= sesr_pkg::SESR_FLAG_RST;
        end else begin
            level1_open_flag_q <= l1_dec_q;
            level2_open_flag_q <= l2_dec_q;
            level3_open_flag_q <= l3_dec_q;
        end
    end

    // ------------------------------------------------------------------
    // sequence tracking and attack response
    // ------------------------------------------------------------------
    logic sequence_active_flag_q;
    logic attack;

    assign attack = sequence_begin_msg_in && sequence_active_flag_q;

    // begin wins over a simultaneous end
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sequence_active_flag_q <= sesr_pkg::SESR_FLAG_RST;
        end else if (sequence_begin_msg_in) begin
            sequence_active_flag_q <= 1'b1;
        end else if (sequence_end_msg_in) begin
            sequence_active_flag_q <= 1'b0;
        end
    end

    // secure reset held low one cycle per attack
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            secure_platform_reset_n_out <= 1'b1;
        end else begin
            secure_platform_reset_n_out <= !attack;
        end
    end

    // rogue flag: set wins over the write-one clear
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rogue_error_flag_out <= sesr_pkg::SESR_FLAG_RST;
        end else if (attack || improper_exit_in) begin
            rogue_error_flag_out <= 1'b1;
        end else if (rogue_clear_in) begin
            rogue_error_flag_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------------
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[sesr_pkg::SESR_SEQ_BIT] = sequence_active_flag_q;
        status_word[sesr_pkg::SESR_L2_BIT]  = level2_open_flag_q;
        status_word[sesr_pkg::SESR_L1_BIT]  = level1_open_flag_q;
        status_word[sesr_pkg::SESR_L3_BIT]  = level3_open_flag_q;
    end

    // same word whatever the window; unmapped reads return zero
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_rdata_out  <= 32'h0000_0000;
            acc_window_out <= 2'h0;
        end else begin
            acc_window_out <= win_now;
            if (acc_valid_in && !acc_write_in && is_status) begin
                acc_rdata_out <= status_word;
            end else if (acc_valid_in && !acc_write_in) begin
                acc_rdata_out <= 32'h0000_0000;
            end
        end
    end

    // status register is read-only in every window, public no-write drops writes
    always_ff @(posedge mclk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            acc_write_done_out <= 1'b0;
        end else begin
            acc_write_done_out <= acc_valid_in && acc_write_in && !is_status
                && (win_now == sesr_pkg::SESR_WIN_SPECIAL
                    || win_now == sesr_pkg::SESR_WIN_PRIVATE);
        end
    end

    // ------------------------------------------------------------------
    // checks: sequence tracking and attack response
    // ------------------------------------------------------------------
    a_seq_set: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sequence_begin_msg_in |=> sequence_active_flag_q)
        else $error("sequence flag not set by begin");
    a_seq_clr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sequence_end_msg_in && !sequence_begin_msg_in |=> !sequence_active_flag_q)
        else $error("sequence flag not cleared by end");
    // the flag must not drift between messages
    a_seq_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !sequence_begin_msg_in && !sequence_end_msg_in |=> $stable(sequence_active_flag_q))
        else $error("sequence flag changed without a message");
    a_attack_reset: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        sequence_begin_msg_in && sequence_active_flag_q
        |=> !secure_platform_reset_n_out && rogue_error_flag_out)
        else $error("second begin not treated as attack");
    // a first begin must never pulse the platform reset
    a_srst_quiet: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !(sequence_begin_msg_in && sequence_active_flag_q) |=> secure_platform_reset_n_out)
        else $error("secure reset without an attack");
    a_rogue_exit: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        improper_exit_in |=> rogue_error_flag_out)
        else $error("rogue flag not set by improper exit");
    a_rogue_clr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        rogue_clear_in && !improper_exit_in && !attack |=> !rogue_error_flag_out)
        else $error("rogue flag not cleared");
    a_rogue_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        rogue_error_flag_out && !rogue_clear_in |=> rogue_error_flag_out)
        else $error("rogue flag lost without a clear");

    // ------------------------------------------------------------------
    // checks: level open flags
    // ------------------------------------------------------------------
    a_l2_open: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        open_level2_cmd_in || open_private_cmd_in |=> ##1 level2_open_flag_q)
        else $error("level2 flag not set");
    a_l2_close: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (close_level2_cmd_in || close_private_cmd_in)
        && !open_level2_cmd_in && !open_private_cmd_in |=> ##1 !level2_open_flag_q)
        else $error("level2 flag not cleared");
    a_l1_track: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        open_level1_cmd_in |=> ##1 level1_open_flag_q)
        else $error("level1 flag not set");
    a_l1_close: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        close_level1_cmd_in && !open_level1_cmd_in |=> ##1 !level1_open_flag_q)
        else $error("level1 flag not cleared");
    a_l3_open: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        open_level3_cmd_in |=> ##1 level3_open_flag_q)
        else $error("level3 flag not set");
    a_l3_track: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        close_level3_cmd_in && !open_level3_cmd_in |=> ##1 !level3_open_flag_q)
        else $error("level3 flag not cleared");
    // a visible flag ahead of the decode state would mislead software
    a_flag_lag: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        level2_open_flag_q == $past(l2_dec_q, sesr_pkg::SESR_DECODE_LAT))
        else $error("visible flag ahead of decode");
    a_l1_lag: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        level1_open_flag_q == $past(l1_dec_q, sesr_pkg::SESR_DECODE_LAT))
        else $error("level1 flag ahead of decode");
    a_l3_lag: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        level3_open_flag_q == $past(l3_dec_q, sesr_pkg::SESR_DECODE_LAT))
        else $error("level3 flag ahead of decode");

    // ------------------------------------------------------------------
    // checks: window decode, read path and write acceptance
    // ------------------------------------------------------------------
    // decode re-derived from the address, not from the decode function
    a_win_special: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (acc_addr_in & sesr_pkg::SESR_WIN_MASK) == sesr_pkg::SESR_PRIV_BASE && acc_special_in
        |=> acc_window_out == sesr_pkg::SESR_WIN_SPECIAL)
        else $error("special window not decoded");
    a_win_private: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (acc_addr_in & sesr_pkg::SESR_WIN_MASK) == sesr_pkg::SESR_PRIV_BASE && !acc_special_in
        |=> acc_window_out == sesr_pkg::SESR_WIN_PRIVATE)
        else $error("private window not decoded");
    a_win_public: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        (acc_addr_in & sesr_pkg::SESR_WIN_MASK) == sesr_pkg::SESR_PUB_BASE
        |=> acc_window_out == sesr_pkg::SESR_WIN_PUBLIC)
        else $error("public window not decoded");
    a_rsvd_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        acc_rdata_out[31:18] == 14'h0000 && !acc_rdata_out[13])
        else $error("reserved status bits nonzero");
    a_unmapped_zero: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        acc_valid_in && !acc_write_in && !is_status |=> acc_rdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        !(acc_valid_in && !acc_write_in) |=> $stable(acc_rdata_out))
        else $error("read data changed without a read");
    a_no_status_wr: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        acc_valid_in && acc_write_in && is_status |=> !acc_write_done_out)
        else $error("status write took effect");
    a_pub_nowrite: assert property (@(posedge mclk_in) disable iff (!rstn_in)
        acc_valid_in && acc_write_in && win_now == sesr_pkg::SESR_WIN_PUBLIC
        |=> !acc_write_done_out)
        else $error("public write took effect");

    c_attack: cover property (@(posedge mclk_in) disable iff (!rstn_in) attack);
    c_pub_read: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        acc_valid_in && !acc_write_in && is_status && win_now == sesr_pkg::SESR_WIN_PUBLIC);
    c_seq_cycle: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        sequence_begin_msg_in ##[1:20] sequence_end_msg_in);
    c_l2_open: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        $rose(level2_open_flag_q));
    c_rogue_clr: cover property (@(posedge mclk_in) disable iff (!rstn_in)
        rogue_error_flag_out && rogue_clear_in);

endmodule : sesr_status_regs

/* verification/sesr_thread_model.sv */
`timescale 1ns/10ps
// processor-thread side: issues register cycles and one-cycle message pulses
module sesr_thread_model (
    input  wire logic        mclk_in,   // platform clock
    input  wire logic        ready_in,  // access accepted
    output logic             valid_out, // access request
    output logic             write_out, // 1 write, 0 read
    output logic             spec_out,  // secure command type
    output logic [31:0]      addr_out,  // byte address
    output logic [31:0]      wdata_out, // write data
    output logic [11:0]      cmd_out    // message and command pulses
);
    initial begin
        valid_out = 1'b0;
        write_out = 1'b0;
        spec_out  = 1'b0;
        addr_out  = 32'h0000_0000;
        wdata_out = 32'h0000_0000;
        cmd_out   = 12'h000;
    end

    // one access, held until the taking edge; address and write data then show the inverse
    task automatic access(input logic wr, input logic sp, input logic [31:0] a,
                          input logic [31:0] d);
        @(posedge mclk_in);
        #1;
        valid_out = 1'b1;
        write_out = wr;
        spec_out  = sp;
        addr_out  = a;
        wdata_out = d;
        @(posedge mclk_in);
        while (!ready_in) @(posedge mclk_in);
        #1;
        valid_out = 1'b0;
        addr_out  = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : access

    // single-cycle pulse on one message line
    task automatic pulse(input int idx);
        @(posedge mclk_in);
        #1;
        cmd_out[idx] = 1'b1;
        @(posedge mclk_in);
        #1;
        cmd_out = 12'h000;
    endtask : pulse
endmodule : sesr_thread_model

/* verification/testbench.sv */
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %s exp=%h got=%h", n, e, g); end end
module testbench;
    logic        mclk_in = 1'b0;
    logic        rstn_in = 1'b0;
    logic        v, w, s, rdy, wdone, d1, d2, d3, rogue, srst_n;
    logic [31:0] a, wd, rdata;
    logic [11:0] cmd;
    logic [1:0]  win;
    logic        seq, l1, l2, l3;
    int          err_total = 0;
    int          comparisons = 0;

    always #20 mclk_in = ~mclk_in;

    sesr_thread_model sesr_thread_model_inst (.mclk_in(mclk_in), .valid_out(v), .write_out(w),
        .spec_out(s), .addr_out(a), .wdata_out(wd), .cmd_out(cmd), .ready_in(rdy));
    sesr_status_regs sesr_status_regs_inst (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .acc_valid_in(v), .acc_write_in(w), .acc_special_in(s), .acc_addr_in(a),
        .acc_wdata_in(wd), .sequence_begin_msg_in(cmd[0]), .sequence_end_msg_in(cmd[1]),
        .open_level1_cmd_in(cmd[2]), .close_level1_cmd_in(cmd[3]),
        .open_level2_cmd_in(cmd[4]), .close_level2_cmd_in(cmd[5]),
        .open_level3_cmd_in(cmd[6]), .close_level3_cmd_in(cmd[7]),
        .open_private_cmd_in(cmd[8]), .close_private_cmd_in(cmd[9]),
        .improper_exit_in(cmd[10]), .rogue_clear_in(cmd[11]), .acc_ready_out(rdy),
        .acc_rdata_out(rdata), .acc_window_out(win), .acc_write_done_out(wdone),
        .level1_dec_out(d1), .level2_dec_out(d2), .level3_dec_out(d3),
        .rogue_error_flag_out(rogue), .secure_platform_reset_n_out(srst_n));

    // expected status word from the bench's own flag copy
    function automatic logic [31:0] exp_sts();
        return {14'h0000, seq, l2, l1, l3, 14'h0000};
    endfunction : exp_sts

    // window 0 special, 1 private, 2 public
    function automatic logic [31:0] base(input int k);
        return (k == 2) ? sesr_pkg::SESR_PUB_BASE : sesr_pkg::SESR_PRIV_BASE;
    endfunction : base

    task automatic rd_sts(input int k);
        sesr_thread_model_inst.access(1'b0, k == 0, base(k), 32'h0000_0000);
        `CHK("status", exp_sts(), rdata)
        `CHK("window", 2'(k + 1), win)
        `CHK("ready_idle", 1'b0, rdy)
    endtask : rd_sts

    task automatic final_report();
        $display("checks=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // watchdog: the sequence needs well under 2000 cycles
    initial begin
        #(40 * 20000);
        err_total++;
        final_report();
    end

    initial begin
        int idx;
        int k;
        {seq, l1, l2, l3} = 4'h0;
        void'($urandom(32'h2b2c2a5a));
        repeat (5) @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        for (k = 0; k < 3; k++) rd_sts(k);
        `CHK("rogue_rst", 1'b0, rogue)
        $display("test reset_values done");
        // every command once, then random; writes to status must not stick
        for (int i = 0; i < 48; i++) begin
            idx = (i < 8) ? i + 2 : $urandom_range(2, 9);
            sesr_thread_model_inst.pulse(idx);
            case (idx)
                2, 3: l1 = (idx == 2);
                4, 5, 8, 9: l2 = (idx == 4 || idx == 8);
                default: l3 = (idx == 6);
            endcase
            `CHK("dec_lvl", {l1, l2, l3}, {d1, d2, d3})
            k = $urandom_range(0, 2);
            sesr_thread_model_inst.access(1'b1, k == 0, base(k), $urandom());
            `CHK("wr_sts_done", 1'b0, wdone)
            rd_sts($urandom_range(0, 2));
        end
        $display("test levels done");
        // open every level and see it shown, then reset in mid-run
        sesr_thread_model_inst.pulse(2);
        sesr_thread_model_inst.pulse(4);
        sesr_thread_model_inst.pulse(6);
        {l1, l2, l3} = 3'h7;
        rd_sts(0);
        rstn_in = 1'b0;
        repeat (2) @(posedge mclk_in);
        #1;
        rstn_in = 1'b1;
        {l1, l2, l3} = 3'h0;
        `CHK("dec_rst", 3'h0, {d1, d2, d3})
        rd_sts(2);
        $display("test mid_reset done");
        // sequence begin, repeated begin as attack, rogue set and clear
        sesr_thread_model_inst.pulse(0);
        seq = 1'b1;
        `CHK("srst_first", 1'b1, srst_n)
        rd_sts(2);
        sesr_thread_model_inst.pulse(0);
        `CHK("srst_attack", 1'b0, srst_n)
        `CHK("rogue_attack", 1'b1, rogue)
        @(posedge mclk_in);
        #1;
        `CHK("srst_pulse", 1'b1, srst_n)
        sesr_thread_model_inst.pulse(11);
        `CHK("rogue_clr", 1'b0, rogue)
        sesr_thread_model_inst.pulse(10);
        `CHK("rogue_exit", 1'b1, rogue)
        sesr_thread_model_inst.pulse(1);
        seq = 1'b0;
        rd_sts(1);
        $display("test sequence done");
        // writes elsewhere: public dropped, private and special accepted
        for (k = 0; k < 3; k++) begin
            sesr_thread_model_inst.access(1'b1, k == 0, base(k) + 32'h4, $urandom());
            `CHK("wr_done", k != 2, wdone)
        end
        sesr_thread_model_inst.access(1'b0, 1'b0, 32'h1000_0000, 32'h0000_0000);
        `CHK("unmapped_win", 2'h0, win)
        `CHK("unmapped_data", 32'h0000_0000, rdata)
        $display("test windows done");
        final_report();
    end
endmodule : testbench
